/* File: adc_ctrl_defs.vh */
// constants for the converter readout control block
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH
`define CLK_PERIOD_NS      8
`define RESULT_WIDTH       24
`define RESULT_POS_FULL    24'h7FFFFF
`define RESULT_NEG_FULL    24'h800000
`define RATE_HS_2M         3'h4
`define RATE_HS_4M         3'h5
`define RATE_RESET         3'h0
`define CS_TRISTATE_NS     8
`define CS_TRISTATE_CYC    (((`CS_TRISTATE_NS) / (`CLK_PERIOD_NS)) < 1 ? 1 : \
	((`CS_TRISTATE_NS) / (`CLK_PERIOD_NS)))
`define SETTLE_LS_CYC      16'h0080
`define SETTLE_HS_CYC      16'h0040
`define PERIOD_LS_CYC      16'h0040
`define PERIOD_HS_CYC      16'h0020
`define OVR_COUNT_LIMIT    4'h8
`define INT_SCLK_DIV       4'h2
`endif

/* File: adc_readout_ctrl.v */
// conversion control and serial readout of a 24-bit delta-sigma converter
//
// Operation
// - releasing chip select puts serial data output into high impedance soon.
// - rate codes 100 and 101 select high-speed mode.
// - every other rate code selects low-speed mode.
// - results are 24 bits, full scale 7FFFFF and 800000.
// - all configuration comes from pins; no programmable registers exist.
// - single-ended link takes internal or host-supplied shift clock.
// - high-speed rates only on differential link, not single-ended.
// - flag out-of-range when inputs stay beyond range for many conversions.
// - sleep pin switches off all activity.
// - results pass through the selected filter path.
// - filter select low means wide-bandwidth, high means low-latency.
// - start is sampled on the master clock rising edge.
// - new start during a conversion flushes it and starts afresh.
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_defs.vh"
module adc_readout_ctrl (
	input  wire        clk,
	input  wire        rst,
	input  wire        ce,
	input  wire        start,
	input  wire [2:0]  rate_code,
	input  wire        filter_path_sel,
	input  wire        fast_filter_cfg,
	input  wire        cs_n,
	input  wire        sleep_pin,
	input  wire        input_overrange_flag,
	input  wire        diff_link_sel,
	input  wire        sclk_ext_sel,
	input  wire        sclk_in,
	input  wire [23:0] wide_result,
	input  wire [23:0] fast_result,
	output reg         sclk_out,
	output reg         sclk_oe,
	output reg         dout,
	output reg         dout_oe,
	output reg         sample_valid_strobe,
	output reg         filter_overrange_flag,
	output reg         high_speed_mode,
	output reg  [23:0] last_result
);
	// ------------------------------------------------------------
	// state encodings
	// ------------------------------------------------------------
	localparam [2:0] ST_IDLE   = 3'b001;
	localparam [2:0] ST_SETTLE = 3'b010;
	localparam [2:0] ST_RUN    = 3'b100;
	localparam [2:0] SH_IDLE   = 3'b001;
	localparam [2:0] SH_LOAD   = 3'b010;
	localparam [2:0] SH_SHIFT  = 3'b100;

	// ------------------------------------------------------------
	// external inputs through synchronisers
	// ------------------------------------------------------------
	wire start_lvl;
	wire start_rise;
	wire cs_lvl;
	wire cs_rise;
	wire sclk_lvl;
	wire sclk_rise;
	wire ovr_lvl;

	edge_sync u_start (.clk(clk), .rst(rst), .ce(ce), .din(start), .level(start_lvl),
		.rise(start_rise), .fall());
	edge_sync u_cs (.clk(clk), .rst(rst), .ce(ce), .din(cs_n), .level(cs_lvl),
		.rise(cs_rise), .fall());
	edge_sync u_sclk (.clk(clk), .rst(rst), .ce(ce), .din(sclk_in), .level(sclk_lvl),
		.rise(sclk_rise), .fall());
	edge_sync u_ovr (.clk(clk), .rst(rst), .ce(ce), .din(input_overrange_flag),
		.level(ovr_lvl), .rise(), .fall());

	// ------------------------------------------------------------
	// configuration pins through synchronisers
	// ------------------------------------------------------------
	// static pins still pass two flops; a change mid-conversion is
	// discarded by the host restart, so no extra skew handling here
	wire [6:0] cfg_pins = {sleep_pin, sclk_ext_sel, diff_link_sel, filter_path_sel, rate_code};
	wire [6:0] cfg_sync;
	genvar     gi;

	generate
		for (gi = 0; gi < 7; gi = gi + 1) begin : g_cfg_sync
			edge_sync u_cfg (
				.clk   (clk),
				.rst   (rst),
				.ce    (ce),
				.din   (cfg_pins[gi]),
				.level (cfg_sync[gi]),
				.rise  (),
				.fall  ()
			);
		end
	endgenerate

	wire [2:0] rate_sync  = cfg_sync[2:0];
	wire       path_sync  = cfg_sync[3];
	wire       diff_sync  = cfg_sync[4];
	wire       ext_sync   = cfg_sync[5];
	wire       sleep_sync = cfg_sync[6];

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	wire rate_hs = (rate_sync == `RATE_HS_2M) || (rate_sync == `RATE_HS_4M);
	// high-speed rates fall back to low speed on the single-ended link
	wire hs_eff = rate_hs & diff_sync;
	// external shift clock exists only on the single-ended link
	wire use_ext = ext_sync & ~diff_sync;

	// ------------------------------------------------------------
	// conversion sequencer
	// ------------------------------------------------------------
	reg [2:0]  conv_state;
	reg [15:0] conv_count;
	reg        conv_done;
	reg        start_held;

	always @(posedge clk) begin
		if (rst || sleep_sync) begin
			conv_state      <= ST_IDLE;
			conv_count      <= 16'h0000;
			conv_done       <= 1'b0;
			start_held      <= 1'b0;
			high_speed_mode <= 1'b0;
		end else if (ce) begin
			conv_done       <= 1'b0;
			high_speed_mode <= hs_eff;
			start_held      <= start_lvl;
			if (start_rise) begin
				// restart flushes the conversion in flight
				conv_state <= ST_SETTLE;
				conv_count <= hs_eff ? `SETTLE_HS_CYC : `SETTLE_LS_CYC;
			end else begin
				case (conv_state)
					ST_IDLE: begin
						conv_count <= 16'h0000;
					end
					ST_SETTLE, ST_RUN: begin
						if (conv_count > 16'h0001) begin
							conv_count <= conv_count - 16'h0001;
						end else begin
							conv_done <= 1'b1;
							// holding start high keeps converting
							if (start_held) begin
								conv_state <= ST_RUN;
								conv_count <= hs_eff ? `PERIOD_HS_CYC : `PERIOD_LS_CYC;
							end else begin
								conv_state <= ST_IDLE;
							end
						end
					end
					default: begin
						conv_state <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// result capture and out-of-range watch
	// ------------------------------------------------------------
	reg [3:0] ovr_count;

	always @(posedge clk) begin
		if (rst || sleep_sync) begin
			last_result           <= 24'h000000;
			sample_valid_strobe   <= 1'b0;
			ovr_count             <= 4'h0;
			filter_overrange_flag <= 1'b0;
		end else if (ce) begin
			sample_valid_strobe <= conv_done;
			if (conv_done) begin
				// low selects wide bandwidth, high selects low latency
				last_result <= path_sync ? fast_result : wide_result;
				if (ovr_lvl) begin
					if (ovr_count != `OVR_COUNT_LIMIT) begin
						ovr_count <= ovr_count + 4'h1;
					end
				end else begin
					ovr_count <= 4'h0;
				end
			end
			filter_overrange_flag <= (ovr_count == `OVR_COUNT_LIMIT);
		end
	end

	// ------------------------------------------------------------
	// internal shift clock
	// ------------------------------------------------------------
	reg [3:0] div_count;
	reg       int_rise;

	always @(posedge clk) begin
		if (rst || sleep_sync) begin
			div_count <= 4'h0;
			sclk_out  <= 1'b0;
			int_rise  <= 1'b0;
		end else if (ce) begin
			int_rise <= 1'b0;
			if (div_count == `INT_SCLK_DIV - 4'h1) begin
				div_count <= 4'h0;
				sclk_out  <= ~sclk_out;
				int_rise  <= ~sclk_out;
			end else begin
				div_count <= div_count + 4'h1;
			end
		end
	end

	always @(posedge clk) begin
		if (rst || sleep_sync) begin
			sclk_oe <= 1'b0;
		end else if (ce) begin
			sclk_oe <= ~use_ext;
		end
	end

	// ------------------------------------------------------------
	// serial shifter
	// ------------------------------------------------------------
	reg [2:0]  sh_state;
	reg [23:0] sh_reg;
	reg [4:0]  sh_left;
	reg [3:0]  cs_wait;
	wire       shift_tick = use_ext ? sclk_rise : int_rise;

	always @(posedge clk) begin
		if (rst || sleep_sync) begin
			sh_state <= SH_IDLE;
			sh_reg   <= 24'h000000;
			sh_left  <= 5'h00;
			dout     <= 1'b0;
		end else if (ce) begin
			case (sh_state)
				SH_IDLE: begin
					if (sample_valid_strobe) begin
						sh_reg   <= last_result;
						sh_state <= SH_LOAD;
					end
				end
				SH_LOAD: begin
					// msb leads, two's complement as converted
					dout     <= sh_reg[23];
					sh_reg   <= {sh_reg[22:0], 1'b0};
					sh_left  <= 5'h17;
					sh_state <= SH_SHIFT;
				end
				SH_SHIFT: begin
					if (sample_valid_strobe) begin
						// a new word overrides an unfinished read
						sh_reg   <= last_result;
						sh_state <= SH_LOAD;
					end else if (shift_tick && !cs_lvl) begin
						if (sh_left == 5'h00) begin
							sh_state <= SH_IDLE;
						end else begin
							dout    <= sh_reg[23];
							sh_reg  <= {sh_reg[22:0], 1'b0};
							sh_left <= sh_left - 5'h01;
						end
					end
				end
				default: begin
					sh_state <= SH_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// data output enable
	// ------------------------------------------------------------
	// release delay in clk cycles, never below one; only the low bits are kept
	wire [31:0] cs_hold_cyc = `CS_TRISTATE_CYC;

	always @(posedge clk) begin
		if (rst || sleep_sync) begin
			cs_wait <= 4'h0;
			dout_oe <= 1'b0;
		end else if (ce) begin
			if (cs_rise) begin
				cs_wait <= cs_hold_cyc[3:0];
			end else if (cs_wait != 4'h0) begin
				cs_wait <= cs_wait - 4'h1;
			end
			if (cs_lvl) begin
				// drop on the first cycle cs_n is seen high; the release delay is not waited for
				if (cs_wait == 4'h1 || cs_wait == 4'h0) begin
					dout_oe <= 1'b0;
				end
			end else begin
				dout_oe <= 1'b1;
			end
		end
	end
endmodule // adc_readout_ctrl
`default_nettype wire

/* File: adc_readout_ctrl_assertions.sv */
// assertions on the readout control ports
`timescale 1ns/100ps
`default_nettype none
module adc_readout_ctrl_assertions (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        start,
	input wire logic [2:0]  rate_code,
	input wire logic        diff_link_sel,
	input wire logic        sclk_ext_sel,
	input wire logic        cs_n,
	input wire logic        sleep_pin,
	input wire logic        sclk_out,
	input wire logic        sclk_oe,
	input wire logic        dout_oe,
	input wire logic        sample_valid_strobe,
	input wire logic        high_speed_mode,
	input wire logic [23:0] last_result
);
	logic [2:0] slp;
	// sleep may pass a synchroniser, so checks rest a few cycles after it
	always @(posedge clk) slp <= {slp[1:0], sleep_pin};
	default clocking @(posedge clk); endclocking
	default disable iff (rst || sleep_pin || slp != 3'h0);
	strobe_width_a: assert property (sample_valid_strobe |=> !sample_valid_strobe)
		else $error("strobe too wide");
	hs_mode_a: assert property (high_speed_mode ==
		($past(rate_code, 3) inside {3'h4, 3'h5} && $past(diff_link_sel, 3)))
		else $error("speed mode");
	cs_tristate_a: assert property (cs_n [*6] |-> !dout_oe) else $error("dout driven");
	sleep_quiet_a: assert property (disable iff (rst) sleep_pin [*5] |->
		!sample_valid_strobe && !dout_oe) else $error("active in sleep");
	result_hold_a: assert property ($changed(last_result) |->
		sample_valid_strobe || $past(sample_valid_strobe)) else $error("result moved");
	restart_quiet_a: assert property ($rose(start) |-> ##4 !sample_valid_strobe [*8])
		else $error("early strobe");
	ext_clock_oe_a: assert property ((sclk_ext_sel && !diff_link_sel) [*4] |-> !sclk_oe)
		else $error("sclk driven");
	sclk_period_a: assert property ($rose(sclk_out) |=> sclk_out ##1 !sclk_out)
		else $error("sclk period");
	cover property (sample_valid_strobe);
	cover property ($rose(cs_n));
	cover property (high_speed_mode);
endmodule // adc_readout_ctrl_assertions
bind adc_readout_ctrl adc_readout_ctrl_assertions adc_readout_ctrl_assertions_inst (.*);
`default_nettype wire

/* File: edge_sync.v */
// two-flop synchroniser with edge detection for an external input
`timescale 1ns/100ps
`default_nettype none
module edge_sync (
	input  wire clk,
	input  wire rst,
	input  wire ce,
	input  wire din,
	output wire level,
	output wire rise,
	output wire fall
);
	reg meta;
	reg stable;
	reg last;

	always @(posedge clk) begin
		if (rst) begin
			meta   <= 1'b0;
			stable <= 1'b0;
			last   <= 1'b0;
		end else if (ce) begin
			meta   <= din;
			stable <= meta;
			last   <= stable;
		end
	end

	assign level = stable;
	assign rise  = ce & stable & ~last;
	assign fall  = ce & ~stable & last;
endmodule // edge_sync
`default_nettype wire

/* File: host_sclk_reader.sv */
// host model that reads results with its own shift clock
`timescale 1ns/100ps
`default_nettype none
module host_sclk_reader (
	input wire logic    clk,
	input wire logic    sample_valid_strobe,
	input wire logic    sclk_ext_sel,
	input wire logic    dout,
	output logic        sclk_in,
	output logic [23:0] word,
	output int          words
);
	initial sclk_in = 1'b0;
	// clock stands still outside frames; bit taken just before each rise
	always @(posedge clk) begin
		if (sample_valid_strobe && sclk_ext_sel) begin
			repeat (4) @(posedge clk);
			for (int i = 0; i < 24; i++) begin
				#2 word = {word[22:0], dout};
				sclk_in = 1'b1;
				#62.5 sclk_in = 1'b0;
				#60.5;
			end
			words++;
		end
	end
endmodule // host_sclk_reader
`default_nettype wire

/* File: tb_adc_readout_ctrl.sv */
// bench for the readout control block
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_defs.vh"
module tb_adc_readout_ctrl;
	logic clk, rst, ce, start, filter_path_sel, fast_filter_cfg, cs_n, sleep_pin, sclk_in;
	logic input_overrange_flag, diff_link_sel, sclk_ext_sel, sclk_out, sclk_oe, dout, dout_oe;
	logic sample_valid_strobe, filter_overrange_flag, high_speed_mode;
	logic [2:0] rate_code;
	logic [23:0] wide_result, fast_result, last_result, word;
	logic [23:0] exp_q[$];
	int words, strobes, cyc, fails, samples_checked, seed, s;
	adc_readout_ctrl adc_readout_ctrl_inst (.*);
	host_sclk_reader host_sclk_reader_inst (.*);
	always #4 clk = ~clk;
	always @(posedge clk) begin
		if (sample_valid_strobe === 1'b1) strobes++;
		cyc++;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end
	task chk(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("checked %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task pulse;
		start = 1;
		repeat (3) @(negedge clk);
		start = 0;
	endtask
	task conv(input logic p, input logic [23:0] v, input logic rs, input logic ext);
		int n, c;
		n = words;
		s = strobes;
		c = 0;
		rate_code = {1'b0, 2'($random(seed))};
		fast_filter_cfg = 1'($random(seed));
		sclk_ext_sel = ext;
		filter_path_sel = p;
		fast_result = p ? v : 24'($random(seed));
		wide_result = p ? 24'($random(seed)) : v;
		exp_q.push_back(v);
		if (rs) begin
			pulse();
			repeat (20) @(negedge clk);
		end
		pulse();
		while (strobes == s && c < 999) begin
			@(negedge clk);
			c++;
		end
		chk(24'(c > `SETTLE_LS_CYC - 10), 1);
		while (ext && words == n && c < 999) begin
			@(negedge clk);
			c++;
		end
		repeat (4) @(negedge clk);
		if (ext) chk(word, exp_q[0]);
		chk(last_result, exp_q.pop_front());
		chk(24'(strobes - s), 1);
	endtask
	initial begin
		seed = 41519;
		clk = 0; rst = 1; ce = 1; start = 0; cs_n = 0; sleep_pin = 0;
		input_overrange_flag = 0; diff_link_sel = 0; sclk_ext_sel = 1; rate_code = `RATE_RESET;
		filter_path_sel = 0; fast_filter_cfg = 0; wide_result = 0; fast_result = 0;
		repeat (3) @(negedge clk);
		rst = 0;
		for (int k = 0; k < 16; k++) begin
			rate_code = k[2:0];
			diff_link_sel = k[3];
			repeat (4) @(negedge clk);
			chk(high_speed_mode, 24'(k[3] && k[2:1] == 2'h2));
		end
		diff_link_sel = 0;
		conv(0, `RESULT_POS_FULL, 0, 1);
		conv(1, `RESULT_NEG_FULL, 1, 1);
		for (int k = 0; k < 4; k++)
			conv(k[0], 24'($random(seed)), k[1], 1);
		conv(1, 24'h5A5A5A, 0, 0);
		chk(dout_oe, 1);
		input_overrange_flag = 1;
		start = 1;
		repeat (10) @(posedge sample_valid_strobe);
		@(negedge clk);
		chk(filter_overrange_flag, 1);
		input_overrange_flag = 0;
		repeat (2) @(posedge sample_valid_strobe);
		@(negedge clk);
		start = 0;
		chk(filter_overrange_flag, 0);
		repeat (100) @(negedge clk);
		sleep_pin = 1;
		s = strobes;
		pulse();
		repeat (300) @(negedge clk);
		chk(24'(strobes - s), 0);
		chk(dout_oe, 0);
		sleep_pin = 0;
		cs_n = 1;
		repeat (6) @(negedge clk);
		chk(dout_oe, 0);
		stop_test();
	end
endmodule // tb_adc_readout_ctrl
`default_nettype wire
